/* logic/dtc_defines.vh */
/*
 dtc_defines.vh: register offsets, field positions, reset values and timing
 counts for the dual timer/counter block.
 assumes: included by bare name from the design files under logic/.
*/
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// word offsets on the wishbone bus (byte address = 4 * index)
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_TL0 8'h8a
`define DTC_IDX_TL1 8'h8b
`define DTC_IDX_TH0 8'h8c
`define DTC_IDX_TH1 8'h8d
`define DTC_IDX_FREQ 8'h8e
`define DTC_IDX_IEN 8'ha8
`define DTC_IDX_IPRI 8'hb8
`define DTC_IDX_ACK 8'hc0

// control register fields
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
// mode register fields
`define DTC_MODE_CT1 6
`define DTC_MODE_M1_HI 5
`define DTC_MODE_M1_LO 4
`define DTC_MODE_CT0 2
`define DTC_MODE_M0_HI 1
`define DTC_MODE_M0_LO 0
// frequency control fields
`define DTC_FREQ_TMR_ONE_PRESCALE_SEL 1
`define DTC_FREQ_TMR_ZERO_PRESCALE_SEL 0
// interrupt enable / priority fields
`define DTC_IEN_GLOBAL 7
`define DTC_IEN_T1 3
`define DTC_IEN_T0 1
`define DTC_IPRI_T1 3
`define DTC_IPRI_T0 1

// mode codes
`define DTC_M_13BIT 2'b00
`define DTC_M_16BIT 2'b01
`define DTC_M_RELOAD 2'b10
`define DTC_M_SPLIT 2'b11

// reset values
`define DTC_RST_BYTE 8'h00

// prescale ratio for the slow timer tick
`define DTC_PRESCALE_DIV 12

`endif

/* logic/dtc_pin_edge.v */
/*
 dtc_pin_edge.v: two-flop synchroniser and falling edge detector for an
 external count pin.
 assumes: pin is asynchronous to clk_i; rst_i synchronous active high.
*/
`timescale 1ns/1ps
module dtc_pin_edge (
   input wire clk_i,
   input wire rst_i,
   input wire pin_i,
   output wire fall_o
);
   reg sync_a;
   reg sync_b;
   reg prev;

   // only sync_b and prev feed the detector, sync_a stays private
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         prev <= 1'b1;
      end else begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   // one pulse per high-to-low change
   assign fall_o = prev & ~sync_b;
endmodule

/* logic/dtc_timer.v */
/*
 dtc_timer.v: two classic timer/counters with 13-bit, 16-bit, 8-bit reload
 and (timer zero) split modes, behind a classic wishbone slave.
 assumes: a wishbone master on clk_i; the cpu pulses the vector acknowledge
 port (or writes the ack register) when it enters a timer interrupt.
*/
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dtc_defines.vh"

// Contract
// - timer zero has 13-bit, 16-bit, 8-bit reload and split modes
// - 13-bit timer zero: high byte bits 12..5, low byte bits 4..0
// - timer zero overflow sets its flag; enabled flag requests interrupt
// - timer zero counts pin falling edges or divided clock
// - setting timer zero run keeps the count and resumes
// - 16-bit timer zero uses all low byte bits
// - timer zero reload mode: low byte overflow reloads from high byte
// - prescale select bit 0 for timer zero, bit 1 for timer one
// - split low byte uses timer zero run, select and flag
// - split high byte counts clock ticks, gated by timer one run
// - split mode stops timer one counting
// - timer one has 13-bit, 16-bit and 8-bit reload modes
// - 13-bit timer one: high byte bits 12..5, low byte bits 4..0
// - timer one overflow sets its flag; enabled flag requests interrupt
// - timer one counts pin falling edges or divided clock
// - setting timer one run keeps the count and resumes
// - 16-bit timer one uses all low byte bits
// - timer one reload mode: low byte overflow reloads from high byte
// - enable register: timer one bit 3, timer zero bit 1
// - priority register: timer one bit 3, timer zero bit 1
// - prescale bit 0 gives clock over 12, 1 gives full clock
// - mode codes 00,01,10,11; timer one code 11 stops
// - interrupt vectoring clears the overflow flag
// - each timer counts only while its run bit is set
module dtc_timer #(
   parameter PRESCALE_DIV = `DTC_PRESCALE_DIV
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [9:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire tmr_zero_count_pin_i,
   input wire tmr_one_count_pin_i,
   input wire tmr_zero_vector_ack_i,
   input wire tmr_one_vector_ack_i,
   output wire tmr_zero_irq_o,
   output wire tmr_one_irq_o,
   output wire tmr_zero_irq_high_o,
   output wire tmr_one_irq_high_o
);
   reg [7:0] timer_control_reg;
   reg [7:0] timer_mode_reg;
   reg [7:0] timer_freq_control_reg;
   reg [7:0] interrupt_enable_mask;
   reg [7:0] interrupt_priority_select;
   reg [7:0] tmr_zero_low_byte;
   reg [7:0] tmr_zero_high_byte;
   reg [7:0] tmr_one_low_byte;
   reg [7:0] tmr_one_high_byte;
   reg [3:0] div_cnt;
   reg [7:0] next_zl;
   reg [7:0] next_zh;
   reg [7:0] next_ol;
   reg [7:0] next_oh;
   reg zero_ovf;
   reg one_ovf;
   reg [7:0] rd_byte;
   wire zero_fall;
   wire one_fall;
   wire slow_tick;
   wire zero_tick;
   wire one_tick;
   wire zero_src;
   wire one_src;
   wire [1:0] zero_mode;
   wire [1:0] one_mode;
   wire zero_run;
   wire one_run;
   wire split;
   wire access;
   wire wr;
   wire [7:0] idx;
   wire [7:0] wbyte;
   wire wr_ack;

   // 13-bit step: low five bits roll into the high byte, top three ignored
   function [16:0] step13;
      input [7:0] hi;
      input [7:0] lo;
      reg [13:0] sum;
      begin
         sum = {1'b0, hi, lo[4:0]} + 14'h0001;
         step13 = {sum[13], sum[12:5], lo[7:5], sum[4:0]};
      end
   endfunction

   // 16-bit step with carry out in bit 16
   function [16:0] step16;
      input [7:0] hi;
      input [7:0] lo;
      begin
         step16 = {1'b0, hi, lo} + 17'h00001;
      end
   endfunction

   // external pins, edge detected in the small module
   dtc_pin_edge u_pin_zero (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(tmr_zero_count_pin_i),
      .fall_o(zero_fall)
   );
   dtc_pin_edge u_pin_one (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(tmr_one_count_pin_i),
      .fall_o(one_fall)
   );

   // shared divide-by-12 enable; free running so both timers see one phase
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= 4'h0;
      end else if (div_cnt == PRESCALE_DIV[3:0] - 4'h1) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end
   assign slow_tick = (div_cnt == PRESCALE_DIV[3:0] - 4'h1);

   assign zero_mode = {timer_mode_reg[`DTC_MODE_M0_HI], timer_mode_reg[`DTC_MODE_M0_LO]};
   assign one_mode = {timer_mode_reg[`DTC_MODE_M1_HI], timer_mode_reg[`DTC_MODE_M1_LO]};
   assign split = (zero_mode == `DTC_M_SPLIT);
   assign zero_run = timer_control_reg[`DTC_CTRL_TR0];
   assign one_run = timer_control_reg[`DTC_CTRL_TR1];
   // timer tick source per prescale bit
   assign zero_src = timer_freq_control_reg[`DTC_FREQ_TMR_ZERO_PRESCALE_SEL] ? 1'b1 : slow_tick;
   assign one_src = timer_freq_control_reg[`DTC_FREQ_TMR_ONE_PRESCALE_SEL] ? 1'b1 : slow_tick;
   assign zero_tick = zero_run & (timer_mode_reg[`DTC_MODE_CT0] ? zero_fall : zero_src);
   // timer one blocked by split mode and by its own stop code
   assign one_tick = one_run & ~split & (one_mode != `DTC_M_SPLIT) &
                     (timer_mode_reg[`DTC_MODE_CT1] ? one_fall : one_src);

   // next count values and overflow events
   always @* begin
      next_zl = tmr_zero_low_byte;
      next_zh = tmr_zero_high_byte;
      next_ol = tmr_one_low_byte;
      next_oh = tmr_one_high_byte;
      zero_ovf = 1'b0;
      one_ovf = 1'b0;
      if (zero_tick) begin
         case (zero_mode)
            `DTC_M_13BIT: begin
               {zero_ovf, next_zh, next_zl} = step13(tmr_zero_high_byte, tmr_zero_low_byte);
            end
            `DTC_M_16BIT: begin
               {zero_ovf, next_zh, next_zl} = step16(tmr_zero_high_byte, tmr_zero_low_byte);
            end
            `DTC_M_RELOAD: begin
               zero_ovf = (tmr_zero_low_byte == 8'hff);
               next_zl = zero_ovf ? tmr_zero_high_byte : tmr_zero_low_byte + 8'h01;
            end
            default: begin
               zero_ovf = (tmr_zero_low_byte == 8'hff);
               next_zl = tmr_zero_low_byte + 8'h01;
            end
         endcase
      end
      // split high byte: clock ticks only, gated by timer one run
      if (split && one_run && one_src) begin
         one_ovf = (tmr_zero_high_byte == 8'hff);
         next_zh = tmr_zero_high_byte + 8'h01;
      end
      if (one_tick) begin
         case (one_mode)
            `DTC_M_13BIT: begin
               {one_ovf, next_oh, next_ol} = step13(tmr_one_high_byte, tmr_one_low_byte);
            end
            `DTC_M_16BIT: begin
               {one_ovf, next_oh, next_ol} = step16(tmr_one_high_byte, tmr_one_low_byte);
            end
            `DTC_M_RELOAD: begin
               one_ovf = (tmr_one_low_byte == 8'hff);
               next_ol = one_ovf ? tmr_one_high_byte : tmr_one_low_byte + 8'h01;
            end
            default: begin
               one_ovf = 1'b0;
            end
         endcase
      end
   end

   // wishbone decode: single cycle ack, dropped the cycle after
   assign access = cyc_i & stb_i & ~ack_o;
   assign idx = adr_i[9:2];
   assign wr = access & we_i & sel_i[0];
   assign wbyte = dat_i[7:0];
   assign wr_ack = wr & (idx == `DTC_IDX_ACK);

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= access;
      end
   end

   // count registers: a software write beats the count in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         tmr_zero_low_byte <= `DTC_RST_BYTE;
         tmr_zero_high_byte <= `DTC_RST_BYTE;
         tmr_one_low_byte <= `DTC_RST_BYTE;
         tmr_one_high_byte <= `DTC_RST_BYTE;
      end else begin
         tmr_zero_low_byte <= (wr && idx == `DTC_IDX_TL0) ? wbyte : next_zl;
         tmr_zero_high_byte <= (wr && idx == `DTC_IDX_TH0) ? wbyte : next_zh;
         tmr_one_low_byte <= (wr && idx == `DTC_IDX_TL1) ? wbyte : next_ol;
         tmr_one_high_byte <= (wr && idx == `DTC_IDX_TH1) ? wbyte : next_oh;
      end
   end

   // configuration registers; mode and frequency reserved bits kept at zero, priority bit 7 kept at zero, enable stored whole
   always @(posedge clk_i) begin
      if (rst_i) begin
         timer_mode_reg <= `DTC_RST_BYTE;
         timer_freq_control_reg <= `DTC_RST_BYTE;
         interrupt_enable_mask <= `DTC_RST_BYTE;
         interrupt_priority_select <= `DTC_RST_BYTE;
      end else if (wr) begin
         if (idx == `DTC_IDX_MODE) begin
            timer_mode_reg <= wbyte & 8'h77;
         end
         if (idx == `DTC_IDX_FREQ) begin
            timer_freq_control_reg <= wbyte & 8'h03;
         end
         if (idx == `DTC_IDX_IEN) begin
            interrupt_enable_mask <= wbyte;
         end
         if (idx == `DTC_IDX_IPRI) begin
            interrupt_priority_select <= wbyte & 8'h7f;
         end
      end
   end

   // control register: run bits by software, flags set by hardware win over any clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_reg <= `DTC_RST_BYTE;
      end else begin
         if (wr && idx == `DTC_IDX_CTRL) begin
            timer_control_reg <= wbyte & 8'hfa;
         end else begin
            if (tmr_zero_vector_ack_i || (wr_ack && wbyte[0])) begin
               timer_control_reg[`DTC_CTRL_TF0] <= 1'b0;
            end
            if (tmr_one_vector_ack_i || (wr_ack && wbyte[1])) begin
               timer_control_reg[`DTC_CTRL_TF1] <= 1'b0;
            end
         end
         if (zero_ovf) begin
            timer_control_reg[`DTC_CTRL_TF0] <= 1'b1;
         end
         if (one_ovf) begin
            timer_control_reg[`DTC_CTRL_TF1] <= 1'b1;
         end
      end
   end

   // read mux; unmapped words read zero but still ack
   always @* begin
      case (idx)
         `DTC_IDX_CTRL: rd_byte = timer_control_reg;
         `DTC_IDX_MODE: rd_byte = timer_mode_reg;
         `DTC_IDX_TL0: rd_byte = tmr_zero_low_byte;
         `DTC_IDX_TL1: rd_byte = tmr_one_low_byte;
         `DTC_IDX_TH0: rd_byte = tmr_zero_high_byte;
         `DTC_IDX_TH1: rd_byte = tmr_one_high_byte;
         `DTC_IDX_FREQ: rd_byte = timer_freq_control_reg;
         `DTC_IDX_IEN: rd_byte = interrupt_enable_mask;
         `DTC_IDX_IPRI: rd_byte = interrupt_priority_select;
         default: rd_byte = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h00000000;
      end else if (access && !we_i) begin
         dat_o <= {24'h000000, rd_byte};
      end
   end

   // requests gated by per-timer and global enables
   assign tmr_zero_irq_o = timer_control_reg[`DTC_CTRL_TF0] & interrupt_enable_mask[`DTC_IEN_T0] &
                           interrupt_enable_mask[`DTC_IEN_GLOBAL];
   assign tmr_one_irq_o = timer_control_reg[`DTC_CTRL_TF1] & interrupt_enable_mask[`DTC_IEN_T1] &
                          interrupt_enable_mask[`DTC_IEN_GLOBAL];
   assign tmr_zero_irq_high_o = interrupt_priority_select[`DTC_IPRI_T0];
   assign tmr_one_irq_high_o = interrupt_priority_select[`DTC_IPRI_T1];
endmodule

/* test/dtc_timer_monitor.sv */
/*
 dtc_timer_monitor.sv: port checks for the dual timer/counter, bus and irq side.
 assumes: bound to dtc_timer, one clock domain, rst_i synchronous active high.
*/
`timescale 1ns/1ps
module dtc_timer_monitor #(
   parameter PRESCALE_DIV = 12
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire tmr_zero_vector_ack_i,
   input wire tmr_one_vector_ack_i,
   input wire tmr_zero_irq_o,
   input wire tmr_one_irq_o,
   input wire tmr_zero_irq_high_o,
   input wire tmr_one_irq_high_o
);
   // one domain, so reset masks everything
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = cyc_i && stb_i;
   wire wreq = req && we_i;

   // bus answer timing
   chk_ack_answer: assert property (req && !ack_o |=> ack_o) else $error("request not answered next cycle");
   chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   chk_ack_cause: assert property (ack_o |-> $past(req)) else $error("ack without request");
   chk_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
   // a raised request only falls through a vector entry or a register write
   chk_irq_zero_hold: assert property (tmr_zero_irq_o && !tmr_zero_vector_ack_i && !wreq |=> tmr_zero_irq_o)
      else $error("timer zero request dropped");
   chk_irq_one_hold: assert property (tmr_one_irq_o && !tmr_one_vector_ack_i && !wreq |=> tmr_one_irq_o)
      else $error("timer one request dropped");
   chk_vec_zero_clear: assert property (tmr_zero_vector_ack_i |=> !tmr_zero_irq_o)
      else $error("timer zero flag not cleared on entry");
   chk_vec_one_clear: assert property (tmr_one_vector_ack_i |=> !tmr_one_irq_o)
      else $error("timer one flag not cleared on entry");
   chk_prio_steady: assert property (!wreq |=> $stable({tmr_one_irq_high_o, tmr_zero_irq_high_o}))
      else $error("priority changed without a write");

   cover property (tmr_zero_vector_ack_i);
   cover property (tmr_one_vector_ack_i);
   cover property (ack_o && we_i);
endmodule

bind dtc_timer dtc_timer_monitor #(.PRESCALE_DIV(PRESCALE_DIV)) dtc_timer_monitor_inst (.clk_i, .rst_i, .cyc_i,
   .stb_i, .we_i, .dat_o, .ack_o, .tmr_zero_vector_ack_i, .tmr_one_vector_ack_i, .tmr_zero_irq_o, .tmr_one_irq_o,
   .tmr_zero_irq_high_o, .tmr_one_irq_high_o);

/* test/dtc_cpu_model.sv */
/*
 dtc_cpu_model.sv: cpu side of one timer interrupt, enters the handler late.
 assumes: irq_i is the enabled request level; the pulse clears its flag.
*/
`timescale 1ns/1ps
module dtc_cpu_model #(
   parameter DELAY = 1
) (
   input wire clk_i,
   input wire rst_i,
   input wire irq_i,
   output logic vector_ack_o = 1'b0
);
   int cnt = 0;
   // one entry pulse after DELAY + 1 cycles of request; the pulse cycle restarts the count
   always @(posedge clk_i) begin
      vector_ack_o <= 1'b0;
      if (rst_i || !irq_i || vector_ack_o) begin
         cnt <= 0;
      end else if (cnt == DELAY) begin
         vector_ack_o <= 1'b1;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* test/dual_classic_timer_counter_tb.sv */
/*
 dual_classic_timer_counter_tb.sv: register rows, then hand-written timer cases.
 assumes: dtc_timer with wishbone slave, two cpu models acking the interrupts.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module dual_classic_timer_counter_tb;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, p0 = 1, p1 = 1;
   logic [9:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, dat_o;
   logic ack, irq0, irq1, hi0, hi1, va0, va1;
   logic [7:0] rd;
   int miscompares = 0, n_tests = 0;
   // register rows: index, write, read back, priority outputs
   logic [7:0] r_idx [7] = '{8'h8c, 8'h89, 8'h8e, 8'ha8, 8'hb8, 8'hb8, 8'h10};
   logic [7:0] r_wd [7] = '{8'ha5, 8'h77, 8'hff, 8'h0a, 8'h02, 8'h08, 8'h55};
   logic [7:0] r_rd [7] = '{8'ha5, 8'h77, 8'h03, 8'h0a, 8'h02, 8'h08, 8'h00};
   logic [1:0] r_hi [7] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b10};

   always #2.5 clk_i = ~clk_i;

   dtc_timer #(.PRESCALE_DIV(12)) dtc_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .tmr_zero_count_pin_i(p0),
      .tmr_one_count_pin_i(p1), .tmr_zero_vector_ack_i(va0), .tmr_one_vector_ack_i(va1), .tmr_zero_irq_o(irq0),
      .tmr_one_irq_o(irq1), .tmr_zero_irq_high_o(hi0), .tmr_one_irq_high_o(hi1));
   // a prompt and a slow handler
   dtc_cpu_model #(.DELAY(1)) dtc_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq0), .vector_ack_o(va0));
   dtc_cpu_model #(.DELAY(6)) dtc_cpu_model_one_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq1),
      .vector_ack_o(va1));

   // classic cycle held until ack, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] idx, wd, output logic [7:0] r);
      int n;
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= 4'h1;
      adr <= {idx, 2'b00};
      dat <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      r = dat_o[7:0];
      if (n >= 40) miscompares++;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] idx, wd);
      logic [7:0] r;
      wb(1'b1, idx, wd, r);
   endtask
   task automatic rc(input logic [7:0] idx, e, m);
      logic [7:0] r;
      wb(1'b0, idx, 8'h00, r);
      `CHK(r & m, e)
   endtask
   // one falling edge, held long enough to pass the synchroniser
   task automatic pin(input bit one);
      if (one) p1 <= 0;
      else p0 <= 0;
      repeat (6) @(posedge clk_i);
      p0 <= 1;
      p1 <= 1;
      repeat (6) @(posedge clk_i);
   endtask
   task wrap_up;
      $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      `CHK({irq0, irq1, hi0, hi1}, 4'h0)
      rc(8'h88, 8'h00, 8'hff);
      for (int i = 0; i < 7; i++) begin
         wr(r_idx[i], r_wd[i]);
         rc(r_idx[i], r_rd[i], 8'hff);
         `CHK({hi1, hi0}, r_hi[i])
      end
      wr(8'hb8, 8'h00);
      wr(8'h8e, 8'h00);
      wr(8'ha8, 8'h00);
      // timer zero 13-bit counter wraps from 0x1fff
      wr(8'h89, 8'h04);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'h1e);
      wr(8'h88, 8'h10);
      pin(0);
      rc(8'h8a, 8'h1f, 8'h1f);
      pin(0);
      rc(8'h8a, 8'h00, 8'h1f);
      rc(8'h8c, 8'h00, 8'hff);
      rc(8'h88, 8'h30, 8'hff);
      `CHK(irq0, 1'b0)
      wr(8'h88, 8'h20);
      pin(0);
      rc(8'h8a, 8'h00, 8'h1f);
      wr(8'h88, 8'h30);
      pin(0);
      rc(8'h8a, 8'h01, 8'h1f);
      // 16-bit carry out of a full low byte
      wr(8'h89, 8'h05);
      wr(8'h8c, 8'h12);
      wr(8'h8a, 8'hff);
      pin(0);
      rc(8'h8c, 8'h13, 8'hff);
      // timer zero reload: low byte wraps to the high byte, flag set again
      wr(8'h89, 8'h06);
      wr(8'h88, 8'h10);
      wr(8'h8c, 8'h80);
      wr(8'h8a, 8'hff);
      pin(0);
      rc(8'h8a, 8'h80, 8'hff);
      rc(8'h8c, 8'h80, 8'hff);
      rc(8'h88, 8'h30, 8'hff);
      // timer one reload counter, stopped timer zero
      wr(8'h89, 8'h65);
      wr(8'h8d, 8'hfe);
      wr(8'h8b, 8'hfe);
      wr(8'h88, 8'h60);
      pin(1);
      pin(1);
      rc(8'h8b, 8'hfe, 8'hff);
      rc(8'h8d, 8'hfe, 8'hff);
      rc(8'h88, 8'he0, 8'hff);
      wr(8'h89, 8'h45);
      wr(8'h8d, 8'h00);
      wr(8'h8b, 8'h1f);
      pin(1);
      rc(8'h8d, 8'h01, 8'hff);
      // 16-bit timer one carries a full low byte into the high byte
      wr(8'h89, 8'h55);
      wr(8'h8b, 8'hff);
      pin(1);
      rc(8'h8d, 8'h02, 8'hff);
      rc(8'h8b, 8'h00, 8'hff);
      wr(8'h89, 8'h75);
      pin(1);
      rc(8'h8b, 8'h00, 8'h1f);
      // enables gate the requests, handlers clear both flags
      wr(8'ha8, 8'h02);
      `CHK({irq1, irq0}, 2'b00)
      wr(8'ha8, 8'h8a);
      repeat (20) @(posedge clk_i);
      rc(8'h88, 8'h40, 8'hff);
      // split mode: high byte on full clock under timer one run, timer one frozen
      wr(8'h88, 8'h00);
      wr(8'h8e, 8'h03);
      wr(8'h8c, 8'h00);
      wr(8'h8b, 8'h11);
      wr(8'h89, 8'h03);
      wr(8'h88, 8'h40);
      repeat (30) @(posedge clk_i);
      rc(8'h8b, 8'h11, 8'hff);
      wb(1'b0, 8'h8c, 8'h00, rd);
      `CHK(rd >= 8'd30, 1'b1)
      // split high byte overflow lands in timer one's flag, not timer zero's
      wr(8'ha8, 8'h00);
      wr(8'h8c, 8'hfe);
      rc(8'h88, 8'h80, 8'ha0);
      // divide by twelve: about forty clocks give three or four ticks
      wr(8'h8e, 8'h00);
      wr(8'h8c, 8'h00);
      repeat (36) @(posedge clk_i);
      wb(1'b0, 8'h8c, 8'h00, rd);
      `CHK(rd >= 8'd3 && rd <= 8'd4, 1'b1)
      wr(8'h88, 8'h00);
      // mid-run reset returns registers and outputs to zero
      wr(8'hb8, 8'h0a);
      wr(8'h88, 8'h50);
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      `CHK({hi1, hi0, irq1, irq0}, 4'h0)
      rc(8'h88, 8'h00, 8'hff);
      rc(8'hb8, 8'h00, 8'hff);
      wrap_up;
   end

   // the whole sequence needs a few hundred cycles
   initial begin
      #100000;
      miscompares++;
      wrap_up;
   end
endmodule
